// File: itx_map.svh
// Offsets, field positions, reset values and masks of the transmit control registers.
// Not included by itx_pkg.sv; assumes inclusion by itx_regs.sv and the testbench; holds definitions only.
`ifndef ITX_MAP_SVH
`define ITX_MAP_SVH

// Register offsets on the register port
`define ITX_OFS_DRV        8'h79
`define ITX_OFS_PIN        8'h7a
`define ITX_OFS_TG         8'h80

// Reset values
`define ITX_RST_DRV        24'h000001
`define ITX_RST_PIN        24'h000000
`define ITX_RST_TG         24'h004e1e

// Writable bits; every other bit is reserved, stored as zero
`define ITX_MASK_DRV       24'h081f1d
`define ITX_MASK_PIN       24'h00003f
`define ITX_MASK_TG        24'h81ffff

// Driver control fields
`define ITX_DRV_PDN_BIT    19
`define ITX_BIAS_PDN_BIT   12
`define ITX_BIAS_CODE_HI   11
`define ITX_BIAS_CODE_LO   8
`define ITX_ALL_BIAS_BIT   4
`define ITX_FOLLOW_BIT     3
`define ITX_INV_EN_BIT     2
`define ITX_TRUE_EN_BIT    0

// Pin source fields
`define ITX_PIN0_LO        4
`define ITX_PIN2_LO        2
`define ITX_PIN1_LO        0

// Timing frame fields
`define ITX_ACONF_DIS_BIT  23
`define ITX_SUBFRAME_HI    16
`define ITX_SUBFRAME_LO    1
`define ITX_TIMING_UNIT_ENABLE_BIT      0

`endif

// File: itx_pkg.sv
// Types shared by the transmit control register bank.
// Assumes itx_map.svh is on the include path.
package itx_pkg;

    // Source codes of a TX pin
    typedef enum logic [1:0]
    {
        ITX_SRC_TRUE = 2'h0,
        ITX_SRC_BAD  = 2'h1,
        ITX_SRC_INV  = 2'h2,
        ITX_SRC_ONE  = 2'h3
    } itx_src_e;

    // Register port request
    typedef struct packed
    {
        logic        wr_en;
        logic        rd_en;
        logic [7:0]  addr;
        logic [23:0] wr_data;
    } itx_req_s;

    // Bias and driver controls toward the analog driver
    typedef struct packed
    {
        logic       driver_power_down;
        logic       bias_current_power_down;
        logic [3:0] bias_current_code;
        logic       true_mod_clock_enable;
        logic       inverted_mod_clock_enable;
    } itx_drv_s;

    // Timing generator controls
    typedef struct packed
    {
        logic        auto_config_disable;
        logic [15:0] subframe_clock_count;
        logic        timing_unit_enable;
    } itx_tg_s;

endpackage

// File: itx_regs.sv
// Transmit control register bank of the illumination path: driver, bias and pin sources.
// Assumes a register port synchronous to clk and a modulation clock sampled at clk.
`timescale 1ns/10ps
`include "itx_map.svh"

// Contract
// - driver power-down bit, reset zero
// - bias power-down bit shuts bias current
// - four-bit bias code, half mA steps
// - all-channel bias when TX0 selected
// - TX1 follows TX0 enable when set
// - inverted clock enable, reset disabled
// - true clock enable, reset enabled
// - TX0 source: true, inverted, one
// - TX2 source uses same encoding
// - TX1 source same encoding, reset zero
// - frame register resets to printed value
// - sub-frame count in bits sixteen to one
// - bit zero enables timing unit
// - auto-config disable keeps user mask values
module itx_regs
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Register port
    input  wire itx_pkg::itx_req_s  req,
    output logic [23:0]             rd_data,
    output logic                    rd_valid,
    // Channel control from the sequencer
    input  wire logic               true_mod_clock,
    input  wire logic               channel0_light_enable,
    input  wire logic [1:0]         channel_select,
    // Driver and timing controls
    output itx_pkg::itx_drv_s       drv,
    output itx_pkg::itx_tg_s        tg,
    // TX pins and per-channel bias enables
    output logic [2:0]              tx_pin,
    output logic [2:0]              bias_enable
);

    logic [23:0] drv_reg;       // Driver control register
    logic [23:0] pin_reg;       // Pin source register
    logic [23:0] tg_reg;        // Timing frame register
    logic [2:0]  chan_active;   // Channel currently selected
    logic [2:0]  bias_next;     // Bias enables before the output flop
    logic [2:0]  pin_next;      // Pin levels before the output flop
    logic        hit_drv;       // Access to driver control
    logic        hit_pin;       // Access to pin source
    logic        hit_tg;        // Access to timing frame

    // Address decode
    assign hit_drv = (req.addr == `ITX_OFS_DRV);
    assign hit_pin = (req.addr == `ITX_OFS_PIN);
    assign hit_tg  = (req.addr == `ITX_OFS_TG);

    // Driver control register; masking keeps reserved bits at zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            drv_reg <= `ITX_RST_DRV;
        else if (req.wr_en && hit_drv)
            drv_reg <= req.wr_data & `ITX_MASK_DRV;
    end

    // Pin source register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_reg <= `ITX_RST_PIN;
        else if (req.wr_en && hit_pin)
            pin_reg <= req.wr_data & `ITX_MASK_PIN;
    end

    // Timing frame register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tg_reg <= `ITX_RST_TG;
        else if (req.wr_en && hit_tg)
            tg_reg <= req.wr_data & `ITX_MASK_TG;
    end

    // Read port: one cycle latency, unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data  <= 24'h000000;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= req.rd_en;
            if (!req.rd_en)
                rd_data <= 24'h000000;
            else if (hit_drv)
                rd_data <= drv_reg;
            else if (hit_pin)
                rd_data <= pin_reg;
            else if (hit_tg)
                rd_data <= tg_reg;
            else
                rd_data <= 24'h000000;
        end
    end

    // Channel selection from the sequencer
    always_comb
    begin
        chan_active = 3'h0;
        chan_active[0] = channel0_light_enable && (channel_select == 2'h0);
        chan_active[2] = channel0_light_enable && (channel_select == 2'h2);
        if (drv_reg[`ITX_FOLLOW_BIT])
            chan_active[1] = chan_active[0];
        else
            chan_active[1] = channel0_light_enable && (channel_select == 2'h1);
    end

    // Bias enables per channel; the analog side scales current by the code
    always_comb
    begin
        bias_next = chan_active;
        if (drv_reg[`ITX_ALL_BIAS_BIT] && chan_active[0])
            bias_next = 3'h7;
        if (drv_reg[`ITX_BIAS_PDN_BIT])
            bias_next = 3'h0;
    end

    // Pin source mux, one per pin; pins share one encoding
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_pin
            localparam int LO = (gi == 0) ? `ITX_PIN0_LO :
                                (gi == 1) ? `ITX_PIN1_LO : `ITX_PIN2_LO;
            itx_pkg::itx_src_e src;
            assign src = itx_pkg::itx_src_e'(pin_reg[LO +: 2]);

            always_comb
            begin
                case (src)
                    itx_pkg::ITX_SRC_TRUE:
                        pin_next[gi] = true_mod_clock && drv_reg[`ITX_TRUE_EN_BIT];
                    itx_pkg::ITX_SRC_INV:
                        pin_next[gi] = !true_mod_clock && drv_reg[`ITX_INV_EN_BIT];
                    itx_pkg::ITX_SRC_ONE:
                        pin_next[gi] = 1'b1;
                    default:
                        pin_next[gi] = 1'b0;
                endcase
                if (drv_reg[`ITX_DRV_PDN_BIT] || !chan_active[gi])
                    pin_next[gi] = 1'b0;
            end

            // Pin output flop; adds one clk of delay to the modulation edge
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    tx_pin[gi] <= 1'b0;
                else
                    tx_pin[gi] <= pin_next[gi];
            end
        end
    endgenerate

    // Bias enable output flop
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            bias_enable <= 3'h0;
        else
            bias_enable <= bias_next;
    end

    // Driver controls as flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drv.driver_power_down         <= 1'b0;
            drv.bias_current_power_down   <= 1'b0;
            drv.bias_current_code         <= 4'h0;
            drv.true_mod_clock_enable     <= 1'b1;
            drv.inverted_mod_clock_enable <= 1'b0;
        end
        else
        begin
            drv.driver_power_down         <= drv_reg[`ITX_DRV_PDN_BIT];
            drv.bias_current_power_down   <= drv_reg[`ITX_BIAS_PDN_BIT];
            drv.bias_current_code         <= drv_reg[`ITX_BIAS_CODE_HI:`ITX_BIAS_CODE_LO];
            drv.true_mod_clock_enable     <= drv_reg[`ITX_TRUE_EN_BIT];
            drv.inverted_mod_clock_enable <= drv_reg[`ITX_INV_EN_BIT];
        end
    end

    // Timing controls as flops; the count reset matches the frame reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tg.auto_config_disable  <= 1'b0;
            tg.subframe_clock_count <= 16'h270f;
            tg.timing_unit_enable   <= 1'b0;
        end
        else
        begin
            tg.auto_config_disable  <= tg_reg[`ITX_ACONF_DIS_BIT];
            tg.subframe_clock_count <= tg_reg[`ITX_SUBFRAME_HI:`ITX_SUBFRAME_LO];
            tg.timing_unit_enable   <= tg_reg[`ITX_TIMING_UNIT_ENABLE_BIT];
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_wr_drv;
        req.wr_en && hit_drv;
    endsequence

    sequence s_wr_tg;
        req.wr_en && hit_tg;
    endsequence

    // Reserved bits of all three registers stay zero whatever is written
    AST_RSV_ZERO: assert property (
        ((drv_reg & ~`ITX_MASK_DRV) == 24'h0) && ((pin_reg & ~`ITX_MASK_PIN) == 24'h0)
        && ((tg_reg & ~`ITX_MASK_TG) == 24'h0))
        else $error("reserved bit stored as one");
    AST_DRV_PDN: assert property (
        s_wr_drv ##0 req.wr_data[19] |-> ##2 drv.driver_power_down)
        else $error("driver power-down not applied");
    AST_PDN_PIN: assert property (
        drv.driver_power_down |-> tx_pin == 3'h0)
        else $error("pin driven while driver down");
    AST_BIAS_OFF: assert property (
        drv.bias_current_power_down |-> bias_enable == 3'h0)
        else $error("bias on while powered down");
    AST_CODE: assert property (
        s_wr_drv |-> ##2 drv.bias_current_code == $past(req.wr_data[11:8], 2))
        else $error("bias code not taken");
    AST_ALL_BIAS: assert property (
        drv_reg[4] && !drv_reg[12] && chan_active[0] |=> bias_enable == 3'h7)
        else $error("all-channel bias missing");
    AST_FOLLOW: assert property (
        drv_reg[3] && channel0_light_enable && channel_select == 2'h0 && !drv_reg[12]
        |=> bias_enable[1])
        else $error("TX1 did not follow TX0");
    AST_INV_OFF: assert property (
        !drv_reg[2] && !drv_reg[0] && pin_reg[5:4] != 2'h3 |=> !tx_pin[0])
        else $error("pin toggled with clocks disabled");
    AST_PIN_ONE: assert property (
        pin_reg[1:0] == 2'h3 && chan_active[1] && !drv_reg[19] |=> tx_pin[1])
        else $error("constant one source not driven");
    AST_BAD_CODE: assert property (
        pin_reg[3:2] == 2'h1 |=> !tx_pin[2])
        else $error("invalid source code drove pin");
    AST_TG_WR: assert property (
        s_wr_tg |-> ##2 tg.subframe_clock_count == $past(req.wr_data[16:1], 2))
        else $error("sub-frame count not taken");

endmodule

// File: itx_emitter.sv
// Emitter diode model that hangs on the TX pins of the transmit control bank.
// Assumes pin and bias levels from itx_regs, sampled on the device clock.
`timescale 1ns/10ps
module itx_emitter
(
    // Clock
    input  wire logic              clk,
    // Drive from the register bank
    input  wire logic [2:0]        tx_pin,
    input  wire logic [2:0]        bias_enable,
    input  wire itx_pkg::itx_drv_s drv,
    // Light per channel
    output logic [2:0]             lit
);
    // A diode glows on pin drive, or on bias with a nonzero code
    always_ff @(posedge clk)
    begin
        lit <= tx_pin | (bias_enable & {3{drv.bias_current_code != 4'h0}});
    end
endmodule

// File: illum_tx_control_regs_tb.sv
// Self-checking bench of the transmit control register bank.
// Assumes itx_pkg, itx_map.svh and the emitter model are compiled first.
`timescale 1ns/10ps
`include "itx_map.svh"
module illum_tx_control_regs_tb;
    localparam logic [7:0] a_drv = `ITX_OFS_DRV;
    localparam logic [7:0] a_pin = `ITX_OFS_PIN;
    localparam logic [7:0] a_tg  = `ITX_OFS_TG;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    itx_pkg::itx_req_s req = '0;
    logic [23:0]       rd_data;
    logic              rd_valid;
    logic              mclk = 1'b0;
    logic              ch_en = 1'b0;
    logic [1:0]        ch_sel = 2'h0;
    itx_pkg::itx_drv_s drv;
    itx_pkg::itx_tg_s  tg;
    logic [2:0]        tx_pin, bias_enable, exp_pin, exp_bias, act;
    logic [2:0]        lit, lit_exp;        // Emitter light and its expectation
    logic [7:0]        exp_drv;             // Expected driver controls, struct order
    logic [23:0]       sh [256];        // Shadow of the register file
    logic [23:0]       dd [256];        // Shadow one edge late, for drv and tg
    logic [23:0]       expq [$];        // Expected read data in order
    logic [7:0]        adr [4] = '{8'h79, 8'h7a, 8'h80, 8'h55};
    logic [31:0]       x = 32'h1385;
    int                mismatches = 0;
    int                comparisons = 0;
    int                cycles = 0;
    int                wq = 0;          // Pin checks paused while a write lands

    always #2.5 clk = ~clk;

    itx_regs dut_u (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
        .rd_valid(rd_valid), .true_mod_clock(mclk), .channel0_light_enable(ch_en),
        .channel_select(ch_sel), .drv(drv), .tg(tg), .tx_pin(tx_pin),
        .bias_enable(bias_enable));
    itx_emitter emit_u (.clk(clk), .tx_pin(tx_pin), .bias_enable(bias_enable),
        .drv(drv), .lit(lit));

    function automatic logic [31:0] nx(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Writable bits per offset; unmapped offsets hold nothing
    function automatic logic [23:0] msk(input logic [7:0] a);
        case (a)
            a_drv:   return `ITX_MASK_DRV;
            a_pin:   return `ITX_MASK_PIN;
            a_tg:    return `ITX_MASK_TG;
            default: return 24'h0;
        endcase
    endfunction

    function automatic logic src(input logic [1:0] c, input logic k, input logic [23:0] d);
        case (c)
            2'h0:    return k & d[0];
            2'h2:    return ~k & d[2];
            2'h3:    return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One access cycle; read data is noted once earlier writes have landed
    task automatic acc(input logic w, input logic r, input logic [7:0] a,
                       input logic [23:0] d, input logic [3:0] p);
        @(posedge clk);
        req <= '{w, r, a, d};
        {ch_en, ch_sel, mclk} <= p;
        if (r)
        begin
            #1;
            expq.push_back(sh[a]);
        end
    endtask

    // Monitor: reads, delayed controls and pins against the shadow
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            foreach (sh[i]) sh[i] = 24'h0;
            sh[a_drv] = `ITX_RST_DRV;
            sh[a_tg] = `ITX_RST_TG;
            dd = sh;
            expq.delete();
            wq = 2;
            exp_pin = 3'h0;
            exp_bias = 3'h0;
            lit_exp = 3'h0;
        end
        else
        begin
            // An unknown valid is not taken as a read; the final queue check catches it
            if (rd_valid === 1'b1 && expq.size() == 0)
                chk(24'hbad, 24'h0);
            else if (rd_valid === 1'b1)
                chk(rd_data, expq.pop_front());
            exp_drv = {dd[a_drv][19], dd[a_drv][12], dd[a_drv][11:8], dd[a_drv][0], dd[a_drv][2]};
            chk(24'(drv), 24'(exp_drv));
            chk(24'(tg), {dd[a_tg][23], dd[a_tg][16:0]});
            // Emitter glows one edge after the pins and bias that it sees
            chk(24'(lit), 24'(lit_exp));
            lit_exp = exp_pin | (exp_bias & {3{dd[a_drv][11:8] != 4'h0}});
            if (wq == 0)
            begin
                chk(24'(tx_pin), 24'(exp_pin));
                chk(24'(bias_enable), 24'(exp_bias));
            end
            // Channel activity, TX1 may follow TX0
            act = ch_en ? (3'b001 << ch_sel) : 3'b000;
            if (sh[a_drv][3])
                act[1] = act[0];
            exp_pin = {src(sh[a_pin][3:2], mclk, sh[a_drv]), src(sh[a_pin][1:0], mclk, sh[a_drv]),
                       src(sh[a_pin][5:4], mclk, sh[a_drv])} & act & {3{~sh[a_drv][19]}};
            exp_bias = (sh[a_drv][4] && act[0]) ? 3'b111 : act;
            exp_bias = sh[a_drv][12] ? 3'b000 : exp_bias;
            dd = sh;
            if (req.wr_en)
            begin
                sh[req.addr] = req.wr_data & msk(req.addr);
                wq = 2;
            end
            else if (wq > 0)
                wq--;
        end
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            test_done;
        end
    end

    initial
    begin
        logic [7:0]  a;
        logic [23:0] d;
        logic [1:0]  s;
        logic        w, r, fol, f2;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, unmapped offset reads zero
        foreach (adr[i]) acc(1'b0, 1'b1, adr[i], 24'h0, 4'h0);
        // reserved bits and unmapped writes are dropped
        foreach (adr[i])
        begin
            acc(1'b1, 1'b0, adr[i], 24'hffffff, 4'h0);
            acc(1'b0, 1'b1, adr[i], 24'h0, 4'h0);
        end
        fol = 1'b1;
        // Random traffic; sel 1 avoided while TX1 follows TX0
        for (int i = 0; i < 3000; i++)
        begin
            x = nx(x);
            a = adr[x[9:8]];
            w = (x[7:4] == 4'h0);
            r = (x[7:4] == 4'h1);
            f2 = fol;
            x = nx(x);
            d = x[23:0] & msk(a);
            if (w && a == a_drv)
                fol = d[3];
            s = x[26:25];
            if (s == 2'h3 || ((f2 | fol) && s == 2'h1))
                s = 2'h0;
            acc(w, r, a, d, {x[24], s, x[27]});
        end
        acc(1'b0, 1'b0, 8'h0, 24'h0, 4'h0);
        // Mid-run reset: written registers must fall back to their reset values
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (adr[i]) acc(1'b0, 1'b1, adr[i], 24'h0, 4'h0);
        acc(1'b0, 1'b0, 8'h0, 24'h0, 4'h0);
        repeat (4) @(posedge clk);
        // Every read asked for has come back
        chk(24'(expq.size()), 24'h0);
        test_done;
    end
endmodule
